// file: dsd_pkg.sv
// Overview of operation
// - select bit 1 makes power-save #0 enter deep sleep, else normal sleep
// - while pin hold is set pins keep frozen state, else direction/latch drive
// - pin hold set only by hardware, cleared by software, resets to 0
// - sleep brown-out flag sets in hardware only if detector enabled and tripped in deep sleep; a software write to control also sets or clears it
// - brown-out in deep sleep never wakes; it re-arms power-on reset, sets the sleep brown-out flag and clears pin hold
// - control register reset only by power-on reset outside deep sleep
// - pin-change event during deep sleep sets wake pin change flag
// - fault during deep sleep sets wake fault flag
// - watchdog timeout during deep sleep sets wake watchdog flag
// - calendar alarm during deep sleep sets wake calendar alarm flag
// - external reset flag sets in hardware only if pin enabled and asserted in deep sleep; a software write to the wake register also sets it
// - writing 1 to select bit clears all wake-source bits
// - supply brown-out reset sets supply brownout flag
// - supply power-on reset sets supply poweron flag, separate from core flag
// - battery poweron flag sets on first power-up, no battery, or low backup
// - battery exit flag sets on power-on exit with backup power present
// - status flags set only by hardware, software can only clear them
// - supply restore after battery mode resets divider and pin registers, not control, wake, status or semaphore words
// - slow cpu enable divides cpu clock; peripheral clock stays full, in sync
// - three-bit ratio picks 1:1 to 1:128, default 1:8
// - return on interrupt set makes interrupt restore full speed
package dsd_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_WAKE = 4'h1;
  localparam logic [3:0] ADDR_STAT = 4'h2;
  localparam logic [3:0] ADDR_SEM0 = 4'h3;
  localparam logic [3:0] ADDR_SEM1 = 4'h4;
  localparam logic [3:0] ADDR_CLOCK_DIVIDER_REGISTER = 4'h5;
  localparam logic [3:0] ADDR_PINDIR = 4'h6;
  localparam logic [3:0] ADDR_PINLAT = 4'h7;
  localparam logic [3:0] ADDR_POWER_SAVE_INSTRUCTION = 4'h8;
  localparam int CTRL_SEL = 15;
  localparam int CTRL_BOR = 1;
  localparam int CTRL_HOLD = 0;
  localparam int WAKE_PINCHG = 8;
  localparam int WAKE_FAULT = 7;
  localparam int WAKE_WDT = 4;
  localparam int WAKE_ALARM = 3;
  localparam int WAKE_XRST = 2;
  localparam int STAT_SBOR = 3;
  localparam int STAT_SPOR = 2;
  localparam int STAT_BPOR = 1;
  localparam int STAT_BEXIT = 0;
  localparam int CD_ROI = 15;
  localparam int CD_RATIO_HI = 14;
  localparam int CD_RATIO_LO = 12;
  localparam int CD_SLOW = 11;
  localparam logic [15:0] CTRL_MASK = 16'h8003;
  localparam logic [15:0] WAKE_MASK = 16'h019C;
  localparam logic [15:0] STAT_MASK = 16'h000F;
  localparam logic [15:0] CLOCK_DIVIDER_REGISTER_MASK = 16'hF800;
  localparam logic [15:0] STAT_RESET = 16'h000E;
  localparam logic [15:0] CLOCK_DIVIDER_REGISTER_RESET = 16'h3000;
  localparam logic [15:0] PINDIR_RESET = 16'hFFFF;
  localparam int PINS = 16;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } dsd_bus_t;
  typedef struct packed {
    logic pin_change;
    logic fault;
    logic watchdog;
    logic alarm;
    logic xrst_enabled;
    logic xrst_assert;
    logic bor_enabled;
    logic bor_detect;
  } dsd_wake_ev_t;
  typedef struct packed {
    logic supply_bor;
    logic supply_por;
    logic battery_por;
    logic battery_exit;
  } dsd_rst_ev_t;
endpackage

// file: dsd_top.sv
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
module dsd_top (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic por_outside_ds_i,
  input wire dsd_pkg::dsd_bus_t bus_i,
  output logic [15:0] rdata_o,
  input wire dsd_pkg::dsd_wake_ev_t wake_ev_i,
  input wire dsd_pkg::dsd_rst_ev_t rst_ev_i,
  input wire logic supply_restore_i,
  input wire logic irq_i,
  input wire logic [dsd_pkg::PINS-1:0] pin_in_i,
  output logic [dsd_pkg::PINS-1:0] pin_out_o,
  output logic [dsd_pkg::PINS-1:0] pin_oe_o,
  output logic deep_sleep_o,
  output logic sleep_o,
  output logic por_rearm_o,
  output logic cpu_clk_en_o
);
  import dsd_pkg::*;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] wake_reg, wake_next;
  logic [15:0] stat_reg, stat_next;
  logic [15:0] sem0_reg, sem1_reg;
  logic [15:0] clock_divider_register_reg, clock_divider_register_next;
  logic [15:0] pindir_reg, pinlat_reg;
  logic [PINS-1:0] frz_out_reg, frz_oe_reg;
  logic in_ds_reg;
  logic [6:0] doze_cnt_reg;
  logic [15:0] rd_mux;
  logic [2:0] ratio;
  logic [6:0] doze_top;
  logic doze_active;
  wire wr_ctrl = bus_i.wr && bus_i.addr == ADDR_CTRL;
  wire wr_wake = bus_i.wr && bus_i.addr == ADDR_WAKE;
  wire wr_stat = bus_i.wr && bus_i.addr == ADDR_STAT;
  wire wr_clock_divider_register = bus_i.wr && bus_i.addr == ADDR_CLOCK_DIVIDER_REGISTER;
  wire wr_power_save_instruction = bus_i.wr && bus_i.addr == ADDR_POWER_SAVE_INSTRUCTION;
  wire sel_set = wr_ctrl && bus_i.wdata[CTRL_SEL];
  // power-save instruction with operand zero
  wire power_save_instruction_zero = wr_power_save_instruction && bus_i.wdata == 16'h0000;
  wire ds_enter = power_save_instruction_zero && ctrl_reg[CTRL_SEL];
  wire ns_enter = power_save_instruction_zero && !ctrl_reg[CTRL_SEL];
  wire ds_wake = in_ds_reg && (wake_ev_i.pin_change || wake_ev_i.fault
    || wake_ev_i.watchdog || wake_ev_i.alarm
    || (wake_ev_i.xrst_enabled && wake_ev_i.xrst_assert));
  // brown-out is excluded from the wake term
  wire ds_bor = in_ds_reg && wake_ev_i.bor_enabled && wake_ev_i.bor_detect;
  wire [15:0] wake_set = {7'h00, wake_ev_i.pin_change, wake_ev_i.fault,
    2'b00, wake_ev_i.watchdog, wake_ev_i.alarm,
    wake_ev_i.xrst_enabled && wake_ev_i.xrst_assert, 2'b00};
  wire [15:0] stat_set = {12'h000, rst_ev_i.supply_bor, rst_ev_i.supply_por,
    rst_ev_i.battery_por, rst_ev_i.battery_exit};

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next[CTRL_SEL] = bus_i.wdata[CTRL_SEL];
      ctrl_next[CTRL_BOR] = bus_i.wdata[CTRL_BOR];
      if (!bus_i.wdata[CTRL_HOLD]) begin
        ctrl_next[CTRL_HOLD] = 1'b0;
      end
    end
    if (ds_enter) begin
      ctrl_next[CTRL_HOLD] = 1'b1;
    end
    if (ds_bor) begin
      ctrl_next[CTRL_BOR] = 1'b1;
      ctrl_next[CTRL_HOLD] = 1'b0;
    end
    ctrl_next = ctrl_next & CTRL_MASK;
  end

  always_comb begin
    wake_next = wake_reg;
    if (wr_wake) begin
      wake_next = bus_i.wdata;
    end
    if (sel_set) begin
      wake_next = 16'h0000;
    end
    if (in_ds_reg) begin
      wake_next = wake_next | wake_set;
    end
    wake_next = wake_next & WAKE_MASK;
  end

  always_comb begin
    stat_next = stat_reg;
    if (wr_stat) begin
      stat_next = stat_reg & bus_i.wdata;
    end
    stat_next = (stat_next | stat_set) & STAT_MASK;
  end

  always_comb begin
    clock_divider_register_next = clock_divider_register_reg;
    if (wr_clock_divider_register) begin
      clock_divider_register_next = bus_i.wdata & CLOCK_DIVIDER_REGISTER_MASK;
    end
    if (irq_i && clock_divider_register_reg[CD_ROI]) begin
      clock_divider_register_next[CD_SLOW] = 1'b0;
    end
  end

  assign ratio = clock_divider_register_reg[CD_RATIO_HI:CD_RATIO_LO];
  assign doze_top = 7'((8'h01 << ratio) - 8'h01);
  assign doze_active = clock_divider_register_reg[CD_SLOW] && ratio != 3'h0;

  assign rd_mux = (bus_i.addr == ADDR_CTRL) ? ctrl_reg :
    (bus_i.addr == ADDR_WAKE) ? wake_reg :
    (bus_i.addr == ADDR_STAT) ? stat_reg :
    (bus_i.addr == ADDR_SEM0) ? sem0_reg :
    (bus_i.addr == ADDR_SEM1) ? sem1_reg :
    (bus_i.addr == ADDR_CLOCK_DIVIDER_REGISTER) ? clock_divider_register_reg :
    (bus_i.addr == ADDR_PINDIR) ? pindir_reg :
    (bus_i.addr == ADDR_PINLAT) ? pinlat_reg : 16'h0000;

  // control, wake source and semaphores survive all but a true power-on
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= 16'h0000;
      wake_reg <= 16'h0000;
      sem0_reg <= 16'h0000;
      sem1_reg <= 16'h0000;
    end else if (por_outside_ds_i) begin
      ctrl_reg <= 16'h0000;
      wake_reg <= 16'h0000;
      sem0_reg <= 16'h0000;
      sem1_reg <= 16'h0000;
    end else begin
      ctrl_reg <= ctrl_next;
      wake_reg <= wake_next;
      if (bus_i.wr && bus_i.addr == ADDR_SEM0) begin
        sem0_reg <= bus_i.wdata;
      end
      if (bus_i.wr && bus_i.addr == ADDR_SEM1) begin
        sem1_reg <= bus_i.wdata;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stat_reg <= STAT_RESET;
    end else begin
      stat_reg <= stat_next;
    end
  end

  // ordinary registers go to reset values on supply restore
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_divider_register_reg <= CLOCK_DIVIDER_REGISTER_RESET;
      pindir_reg <= PINDIR_RESET;
      pinlat_reg <= 16'h0000;
    end else if (supply_restore_i) begin
      clock_divider_register_reg <= CLOCK_DIVIDER_REGISTER_RESET;
      pindir_reg <= PINDIR_RESET;
      pinlat_reg <= 16'h0000;
    end else begin
      clock_divider_register_reg <= clock_divider_register_next;
      if (bus_i.wr && bus_i.addr == ADDR_PINDIR) begin
        pindir_reg <= bus_i.wdata;
      end
      if (bus_i.wr && bus_i.addr == ADDR_PINLAT) begin
        pinlat_reg <= bus_i.wdata;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_ds_reg <= 1'b0;
      sleep_o <= 1'b0;
      por_rearm_o <= 1'b0;
    end else begin
      if (ds_enter) begin
        in_ds_reg <= 1'b1;
      end else if (ds_wake || por_outside_ds_i) begin
        in_ds_reg <= 1'b0;
      end
      por_rearm_o <= ds_bor;
      if (ns_enter) begin
        sleep_o <= 1'b1;
      end else if (bus_i.wr || irq_i) begin
        sleep_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deep_sleep_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      deep_sleep_o <= ds_enter || (in_ds_reg && !ds_wake && !por_outside_ds_i);
      rdata_o <= bus_i.rd ? rd_mux : 16'h0000;
    end
  end

  // snapshot of the pin drive taken at deep sleep entry
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          frz_out_reg[g] <= 1'b0;
          frz_oe_reg[g] <= 1'b0;
          pin_out_o[g] <= 1'b0;
          pin_oe_o[g] <= 1'b0;
        end else begin
          if (ds_enter) begin
            frz_out_reg[g] <= pinlat_reg[g];
            frz_oe_reg[g] <= !pindir_reg[g];
          end
          if (ctrl_reg[CTRL_HOLD]) begin
            pin_out_o[g] <= frz_out_reg[g];
            pin_oe_o[g] <= frz_oe_reg[g];
          end else begin
            pin_out_o[g] <= pinlat_reg[g];
            pin_oe_o[g] <= !pindir_reg[g];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      doze_cnt_reg <= 7'h00;
      cpu_clk_en_o <= 1'b1;
    end else begin
      if (!doze_active || doze_cnt_reg >= doze_top) begin
        doze_cnt_reg <= 7'h00;
      end else begin
        doze_cnt_reg <= doze_cnt_reg + 7'h01;
      end
      // one cpu enable per ratio period, aligned to the peripheral clock
      cpu_clk_en_o <= !doze_active || doze_cnt_reg >= doze_top;
    end
  end
endmodule

// file: dsd_asserts.sv
`timescale 1ns/1ps
module dsd_asserts
  import dsd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire dsd_pkg::dsd_bus_t bus_i,
  input wire dsd_pkg::dsd_wake_ev_t wake_ev_i,
  input wire logic irq_i,
  input wire logic deep_sleep_o,
  input wire logic sleep_o,
  input wire logic por_rearm_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic bor = wake_ev_i.bor_enabled && wake_ev_i.bor_detect;
  wire logic wk = |wake_ev_i[7:2];
  wire logic ent = bus_i.wr && bus_i.addr == ADDR_POWER_SAVE_INSTRUCTION && bus_i.wdata == 16'h0;
  property p_enter;
    ent && !deep_sleep_o && !irq_i && !wk |=> sleep_o ^ deep_sleep_o;
  endproperty
  a_enter: assert property (p_enter) else $error("no sleep entry");
  property p_excl; !(sleep_o && deep_sleep_o); endproperty
  a_excl: assert property (p_excl) else $error("two sleep modes");
  property p_irq; sleep_o && irq_i && !bus_i.wr |=> !sleep_o; endproperty
  a_irq: assert property (p_irq) else $error("sleep kept on irq");
  property p_wake;
    deep_sleep_o && |wake_ev_i[7:4] && !bus_i.wr |=> !deep_sleep_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on event");
  property p_xrst;
    deep_sleep_o && wake_ev_i.xrst_enabled && wake_ev_i.xrst_assert
      && !bus_i.wr |=> !deep_sleep_o;
  endproperty
  a_xrst: assert property (p_xrst) else $error("no wake on reset pin");
  property p_stay;
    bor && deep_sleep_o && !wk && !irq_i |=> deep_sleep_o && por_rearm_o;
  endproperty
  a_stay: assert property (p_stay) else $error("brown-out woke");
  property p_rearm; por_rearm_o |-> $past(bor && deep_sleep_o); endproperty
  a_rearm: assert property (p_rearm) else $error("stray rearm");
  property p_noen;
    deep_sleep_o && wake_ev_i.bor_detect && !wake_ev_i.bor_enabled
      |=> !por_rearm_o;
  endproperty
  a_noen: assert property (p_noen) else $error("disabled bor acted");
endmodule
bind dsd_top dsd_asserts u_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
  .wake_ev_i(wake_ev_i), .irq_i(irq_i), .deep_sleep_o(deep_sleep_o),
  .sleep_o(sleep_o), .por_rearm_o(por_rearm_o)
);

// file: dsd_top_test.sv
`timescale 1ns/1ps
module dsd_top_test;
  import dsd_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, por = 1'b0, sres = 1'b0, irq = 1'b0;
  dsd_bus_t bus = '0;
  dsd_wake_ev_t wev = '0;
  dsd_rst_ev_t rev = '0;
  logic [15:0] rdata, pout, poe;
  logic ds, sl, rearm, cen;
  logic [7:0] evs [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0C, 8'h04};
  logic [15:0] wks [6] = '{16'h0100, 16'h0080, 16'h0010, 16'h0008,
                           16'h0004, 16'h0000};
  int fails = 0, n_tests = 0, i, g;
  always #20 clk = ~clk;
  dsd_top uut (.mclk_i(clk), .rst_n_i(rst_n), .por_outside_ds_i(por),
    .bus_i(bus), .rdata_o(rdata), .wake_ev_i(wev), .rst_ev_i(rev),
    .supply_restore_i(sres), .irq_i(irq), .pin_in_i(16'h0),
    .pin_out_o(pout), .pin_oe_o(poe), .deep_sleep_o(ds), .sleep_o(sl),
    .por_rearm_o(rearm), .cpu_clk_en_o(cen));
  task chk(string n, logic [15:0] s, logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // every task but chk, gap and stop_test starts on an edge and ends 1 ns into the next cycle
  task wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    #1;
  endtask
  task rd(logic [3:0] a, logic [15:0] e);
    @(posedge clk);
    bus <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1 chk($sformatf("reg %h", a), rdata, e);
  endtask
  task ev(dsd_wake_ev_t w, dsd_rst_ev_t r, logic s, logic q);
    @(posedge clk);
    {wev, rev, sres, irq} <= {w, r, s, q};
    @(posedge clk);
    {wev, rev, sres, irq} <= 14'h0000;
    #1;
  endtask
  task gap(output int c);
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (cen !== 1'b1 && c < 300);
  endtask
  task stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // whole run is about 1000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_STAT, 16'h000E);
    rd(ADDR_CLOCK_DIVIDER_REGISTER, 16'h3000);
    rd(ADDR_CTRL, 16'h0);
    rd(ADDR_WAKE, 16'h0);
    rd(4'hF, 16'h0);
    $display("reset values done");
    for (i = 0; i < 4; i++) begin
      wr(ADDR_STAT, 16'h0);
      wr(ADDR_STAT, 16'hFFFF);
      rd(ADDR_STAT, 16'h0);
      ev('0, 4'h8 >> i, 1'b0, 1'b0);
      rd(ADDR_STAT, 16'h8 >> i);
    end
    $display("status done");
    for (i = 0; i < 6; i++) begin
      wr(ADDR_CTRL, 16'h8000);
      rd(ADDR_WAKE, 16'h0);
      wr(ADDR_POWER_SAVE_INSTRUCTION, 16'h0);
      chk("deep", {15'h0, ds}, 16'h1);
      rd(ADDR_CTRL, 16'h8001);
      ev(evs[i], '0, 1'b0, 1'b0);
      rd(ADDR_WAKE, wks[i]);
    end
    ev(8'h40, '0, 1'b0, 1'b0);
    $display("wake sources done");
    wr(ADDR_PINDIR, 16'h0F0F);
    wr(ADDR_PINLAT, 16'h00FF);
    wr(ADDR_CTRL, 16'h0001);
    chk("held oe", poe, 16'h0);
    wr(ADDR_CTRL, 16'h0);
    // pin drive follows the hold flag one clock later
    @(posedge clk);
    #1 chk("oe", poe, 16'hF0F0);
    chk("out", pout & poe, 16'h00F0);
    wr(ADDR_CTRL, 16'h0001);
    rd(ADDR_CTRL, 16'h0);
    $display("pin hold done");
    wr(ADDR_CTRL, 16'h8000);
    wr(ADDR_POWER_SAVE_INSTRUCTION, 16'h0);
    ev(8'h01, '0, 1'b0, 1'b0);
    rd(ADDR_CTRL, 16'h8001);
    ev(8'h03, '0, 1'b0, 1'b0);
    chk("rearm", {15'h0, rearm}, 16'h1);
    chk("stay deep", {15'h0, ds}, 16'h1);
    rd(ADDR_CTRL, 16'h8002);
    ev(8'h40, '0, 1'b0, 1'b0);
    wr(ADDR_CTRL, 16'h0);
    wr(ADDR_POWER_SAVE_INSTRUCTION, 16'h0);
    chk("sleep", {14'h0, sl, ds}, 16'h2);
    ev('0, '0, 1'b0, 1'b1);
    $display("brown-out done");
    wr(ADDR_CTRL, 16'h8002);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // the reset pin is a true power-on: deep sleep state is lost too
    rd(ADDR_CTRL, 16'h0);
    rd(ADDR_STAT, 16'h000E);
    wr(ADDR_CTRL, 16'h8002);
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    rd(ADDR_CTRL, 16'h0);
    wr(ADDR_SEM0, 16'h1234);
    wr(ADDR_SEM1, 16'hABCD);
    wr(ADDR_CLOCK_DIVIDER_REGISTER, 16'hF800);
    ev('0, '0, 1'b1, 1'b0);
    rd(ADDR_SEM0, 16'h1234);
    rd(ADDR_SEM1, 16'hABCD);
    rd(ADDR_CLOCK_DIVIDER_REGISTER, 16'h3000);
    rd(ADDR_PINDIR, 16'hFFFF);
    $display("retention done");
    for (i = 0; i < 8; i++) begin
      wr(ADDR_CLOCK_DIVIDER_REGISTER, 16'h0800 | 16'(i << 12));
      gap(g);
      gap(g);
      gap(g);
      chk("cpu gap", g[15:0], 16'(1 << i));
    end
    wr(ADDR_CLOCK_DIVIDER_REGISTER, 16'hB800);
    ev('0, '0, 1'b0, 1'b1);
    gap(g);
    gap(g);
    chk("roi gap", g[15:0], 16'h1);
    rd(ADDR_CLOCK_DIVIDER_REGISTER, 16'hB000);
    wr(ADDR_CLOCK_DIVIDER_REGISTER, 16'h3800);
    ev('0, '0, 1'b0, 1'b1);
    gap(g);
    gap(g);
    gap(g);
    chk("no roi gap", g[15:0], 16'h8);
    $display("doze done");
    stop_test;
  end
endmodule
